// >>> shared/lcg_defines.vh
// Purpose: Shared constants for the logic cell gate-select block
// Assumes: Registers sit one per aligned 32-bit Wishbone word, data in the low byte
// Notes:   Reset values stand in for the undefined power-up state of the fields
`ifndef LCG_DEFINES_VH
`define LCG_DEFINES_VH

// Register byte offsets
`define LCG_OFF_THIRD_SEL   8'h00
`define LCG_OFF_FOURTH_SEL  8'h04
`define LCG_OFF_GATE0_EN    8'h08
`define LCG_OFF_GATE1_EN    8'h0C
`define LCG_OFF_GATE2_EN    8'h10
`define LCG_OFF_GATE_INV    8'h14
`define LCG_OFF_STATUS      8'h18

// Address width seen by the slave
`define LCG_ADR_W           8

// Source code field: bits 4 to 0
`define LCG_SRC_MSB         4
`define LCG_SRC_LSB         0
`define LCG_SRC_W           5

// Gate enable field: whole low byte
`define LCG_EN_W            8

// Gate output invert field: one bit per gate, bits 2 to 0
`define LCG_INV_W           3

// Reset values after power-on
`define LCG_RST_SRC         5'h00
`define LCG_RST_EN          8'h00
`define LCG_RST_INV         3'h0
`define LCG_RST_GATE        3'h0
`define LCG_RST_DAT         32'h00000000

// Padding widths for read data
`define LCG_PAD_SRC         27
`define LCG_PAD_EN          24
`define LCG_PAD_INV         29
`define LCG_PAD_STAT        27

`endif

// >>> design/lcg_gate.v
// Purpose: One data gate: OR of enabled true and inverted data inputs
// Assumes: Enable byte laid out input 4 true at bit 7 down to input 1 inverted at bit 0
// Notes:   Purely combinational; the top registers the result
`timescale 1ns/10ps
module lcg_gate (
  input  wire [7:0] inputEnables,
  input  wire [3:0] dataIn,
  input  wire       outputInvert,
  output wire       gateValue
);

  wire [3:0] termTrue;
  wire [3:0] termInv;
  wire       gateOr;

  // Odd bit gates the true form, even bit the inverted form
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : gTerm
      assign termTrue[k] = inputEnables[2*k+1] & dataIn[k];
      assign termInv[k]  = inputEnables[2*k] & ~dataIn[k];
    end
  endgenerate

  // OR of terms, zero when none enabled
  assign gateOr    = |{termTrue, termInv};
  assign gateValue = gateOr ^ outputInvert;

endmodule // lcg_gate

// >>> design/lcg_top.v
// Purpose: Input selection and gating for gates 0 to 2 of a configurable logic cell
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low byte of each word
// Notes:   Gate outputs are registered, so they lag the inputs by one clock
//
// Behaviour
// - Third input source chosen by 5-bit code in bits 4:0; bits 7:5 read zero.
// - Fourth input source chosen by own 5-bit code in bits 4:0; upper bits zero.
// - Gate 0 has eight enables, true and inverted per input, input 4 true at bit 7.
// - Gate 1 has its own eight enable bits in the same order.
// - Gate 2 has its own eight enable bits in the same order.
// - Set enable feeds that input form into the gate; clear keeps it out.
// - Select and enable fields undefined at power-up, kept through other resets.
// - Each gate output may be inverted by its own polarity bit.
`timescale 1ns/10ps
`include "lcg_defines.vh"
module lcg_top #(
  parameter SRC_COUNT = 32
) (
  input  wire                    clock,
  input  wire                    rstn,
  // Wishbone classic slave
  input  wire                    cyc_i,
  input  wire                    stb_i,
  input  wire                    we_i,
  input  wire [`LCG_ADR_W-1:0]   adr_i,
  input  wire [31:0]             dat_i,
  input  wire [3:0]              sel_i,
  output reg  [31:0]             dat_o,
  output reg                     ack_o,
  // Data inputs
  input  wire                    dataInputOne,
  input  wire                    dataInputTwo,
  input  wire [SRC_COUNT-1:0]    sourceBus,
  // Gate outputs toward the logic function
  output reg  [2:0]              gateOut
);

  // Configuration registers
  reg  [`LCG_SRC_W-1:0]  thirdInputSourceSelect_ff;
  reg  [`LCG_SRC_W-1:0]  fourthInputSourceSelect_ff;
  reg  [7:0]             gateZeroInputEnables_ff;
  reg  [7:0]             gateOneInputEnables_ff;
  reg  [7:0]             gateTwoInputEnables_ff;
  reg  [`LCG_INV_W-1:0]  gateOutputInvert_ff;

  // Bus side
  reg  [31:0]            nxt_dat;
  wire                   busReq;
  wire                   busWrite;

  // Selected data and gate results
  reg                    dataInputThree;
  reg                    dataInputFour;
  wire [3:0]             dataVec;
  wire [2:0]             gateValue;

  // One new request per handshake: ack must fall before the next is taken
  assign busReq   = cyc_i & stb_i & ~ack_o;
  // Data lives in byte lane 0, so only that lane enables a write.
  // The write lands where the master samples ack, not one edge earlier.
  assign busWrite = cyc_i & stb_i & ack_o & we_i & sel_i[0];

  // Source multiplexers; codes beyond the source count read as zero
  always @* begin
    dataInputThree = 1'b0;
    dataInputFour  = 1'b0;
    if (thirdInputSourceSelect_ff < SRC_COUNT) begin
      dataInputThree = sourceBus[thirdInputSourceSelect_ff];
    end
    if (fourthInputSourceSelect_ff < SRC_COUNT) begin
      dataInputFour = sourceBus[fourthInputSourceSelect_ff];
    end
  end

  assign dataVec = {dataInputFour, dataInputThree, dataInputTwo, dataInputOne};

  lcg_gate uGate0 (
    .inputEnables (gateZeroInputEnables_ff),
    .dataIn       (dataVec),
    .outputInvert (gateOutputInvert_ff[0]),
    .gateValue    (gateValue[0])
  );

  lcg_gate uGate1 (
    .inputEnables (gateOneInputEnables_ff),
    .dataIn       (dataVec),
    .outputInvert (gateOutputInvert_ff[1]),
    .gateValue    (gateValue[1])
  );

  lcg_gate uGate2 (
    .inputEnables (gateTwoInputEnables_ff),
    .dataIn       (dataVec),
    .outputInvert (gateOutputInvert_ff[2]),
    .gateValue    (gateValue[2])
  );

  // Read mux; unmapped words and reserved bits read as zero
  always @* begin
    nxt_dat = `LCG_RST_DAT;
    case (adr_i)
      `LCG_OFF_THIRD_SEL: begin
        nxt_dat = {{`LCG_PAD_SRC{1'b0}}, thirdInputSourceSelect_ff};
      end
      `LCG_OFF_FOURTH_SEL: begin
        nxt_dat = {{`LCG_PAD_SRC{1'b0}}, fourthInputSourceSelect_ff};
      end
      `LCG_OFF_GATE0_EN: begin
        nxt_dat = {{`LCG_PAD_EN{1'b0}}, gateZeroInputEnables_ff};
      end
      `LCG_OFF_GATE1_EN: begin
        nxt_dat = {{`LCG_PAD_EN{1'b0}}, gateOneInputEnables_ff};
      end
      `LCG_OFF_GATE2_EN: begin
        nxt_dat = {{`LCG_PAD_EN{1'b0}}, gateTwoInputEnables_ff};
      end
      `LCG_OFF_GATE_INV: begin
        nxt_dat = {{`LCG_PAD_INV{1'b0}}, gateOutputInvert_ff};
      end
      // Live state: selected inputs 4 and 3, then registered gate outputs
      `LCG_OFF_STATUS: begin
        nxt_dat = {{`LCG_PAD_STAT{1'b0}}, dataInputFour, dataInputThree, gateOut};
      end
      default: begin
        nxt_dat = `LCG_RST_DAT;
      end
    endcase
  end

  // Handshake: ack one cycle after the request, dropped the cycle after
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_o <= 1'b0;
      dat_o <= `LCG_RST_DAT;
    end else begin
      ack_o <= busReq;
      if (busReq && !we_i) begin
        dat_o <= nxt_dat;
      end
    end
  end

  // Configuration writes land at the edge where ack is seen high.
  // rstn is the power-on reset; the fields have no other reset input,
  // so any other system reset leaves them untouched.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // defined stand-in for the undefined power-up value
      thirdInputSourceSelect_ff  <= `LCG_RST_SRC;
      fourthInputSourceSelect_ff <= `LCG_RST_SRC;
      gateZeroInputEnables_ff    <= `LCG_RST_EN;
      gateOneInputEnables_ff     <= `LCG_RST_EN;
      gateTwoInputEnables_ff     <= `LCG_RST_EN;
      gateOutputInvert_ff        <= `LCG_RST_INV;
    end else if (busWrite) begin
      case (adr_i)
        `LCG_OFF_THIRD_SEL: begin
          thirdInputSourceSelect_ff <= dat_i[`LCG_SRC_MSB:`LCG_SRC_LSB];
        end
        `LCG_OFF_FOURTH_SEL: begin
          fourthInputSourceSelect_ff <= dat_i[`LCG_SRC_MSB:`LCG_SRC_LSB];
        end
        `LCG_OFF_GATE0_EN: begin
          gateZeroInputEnables_ff <= dat_i[`LCG_EN_W-1:0];
        end
        `LCG_OFF_GATE1_EN: begin
          gateOneInputEnables_ff <= dat_i[`LCG_EN_W-1:0];
        end
        `LCG_OFF_GATE2_EN: begin
          gateTwoInputEnables_ff <= dat_i[`LCG_EN_W-1:0];
        end
        `LCG_OFF_GATE_INV: begin
          gateOutputInvert_ff <= dat_i[`LCG_INV_W-1:0];
        end
        default: begin
          gateOutputInvert_ff <= gateOutputInvert_ff;
        end
      endcase
    end
  end

  // Registered gate outputs keep glitches of the OR tree off the ports
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gateOut <= `LCG_RST_GATE;
    end else begin
      gateOut <= gateValue;
    end
  end

endmodule // lcg_top

// >>> tb/lcg_top_chk.sv
// Purpose: Bus timing and read-data checks for lcg_top
// Assumes: Register offsets from lcg_defines.vh
// Notes:   Sees only the top ports; config itself is judged by the bench
`timescale 1ns/10ps
`include "lcg_defines.vh"
module lcg_chk #(
  parameter SRC_COUNT = 32
) (
  input wire logic                  clock,
  input wire logic                  rstn,
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic                  we_i,
  input wire logic [`LCG_ADR_W-1:0] adr_i,
  input wire logic [31:0]           dat_i,
  input wire logic [3:0]            sel_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  input wire logic                  dataInputOne,
  input wire logic                  dataInputTwo,
  input wire logic [SRC_COUNT-1:0]  sourceBus,
  input wire logic [2:0]            gateOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Read request in flight
  wire rd = cyc_i && stb_i && !we_i;
  // A request the slave may take
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_timely: assert property (s_take |=> ack_o) else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("ack without request");
  a_third_pad: assert property (ack_o && $past(rd && adr_i == `LCG_OFF_THIRD_SEL) |->
    dat_o[31:5] == 0) else $error("third select pad");
  a_fourth_pad: assert property (ack_o && $past(rd && adr_i == `LCG_OFF_FOURTH_SEL) |->
    dat_o[31:5] == 0) else $error("fourth select pad");
  a_status_gates: assert property (ack_o && $past(rd && adr_i == `LCG_OFF_STATUS) |->
    dat_o[2:0] == $past(gateOut)) else $error("status gates");
  a_unmapped_zero: assert property (ack_o && $past(rd && adr_i > `LCG_OFF_STATUS) |->
    dat_o == 0) else $error("unmapped read");
  a_write_holds: assert property (ack_o && $past(we_i) |-> $stable(dat_o))
    else $error("write moved read data");
  a_reset_clean: assert property ($rose(rstn) |-> gateOut == 0 && !ack_o)
    else $error("reset state");
endmodule // lcg_chk

bind lcg_top lcg_chk #(.SRC_COUNT(SRC_COUNT)) u_chk (.clock(clock), .rstn(rstn),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .dat_o(dat_o), .ack_o(ack_o), .dataInputOne(dataInputOne),
  .dataInputTwo(dataInputTwo), .sourceBus(sourceBus), .gateOut(gateOut));

// >>> tb/lcg_top_tb_top.sv
// Purpose: Self-checking bench for lcg_top
// Assumes: Classic Wishbone answer one cycle after the request is taken
// Notes:   Gate outputs are compared two edges after inputs settle
`timescale 1ns/10ps
`include "lcg_defines.vh"
module lcg_top_tb_top;
  logic        clock, rstn, cyc, stb, we, dIn1, dIn2, ack;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, src, r;
  logic [3:0]  sel;
  logic [2:0]  gOut, inv, gx;
  logic [7:0]  en [3];
  logic [4:0]  c3, c4;
  int          failCount, nCompared, n, g;

  lcg_top u_dut (.clock(clock), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .dataInputOne(dIn1), .dataInputTwo(dIn2), .sourceBus(src), .gateOut(gOut));

  // OR of enabled true and inverted terms
  function automatic logic gexp(input logic [7:0] e, input logic [3:0] d);
    return |(e & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic finishTest;
    if (failCount == 0 && nCompared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One classic cycle; held until ack is sampled, bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    sel <= s;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (ack !== 1'b1 && i < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      failCount++;
      finishTest;
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    {cyc, stb, we, adr, wdat, sel, dIn1, dIn2, src, rstn} = '0;
    {failCount, nCompared, inv} = '0;
    en = '{8'h00, 8'h00, 8'h00};
    void'($urandom(4674));
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    // Every register reads cleared after power-up
    for (n = 0; n < 7; n++) begin
      bus(1'b0, 8'(n * 4), 8'h00, 4'hF);
      chk(r, 32'h00000000);
    end
    // Write without the low lane is dropped; unmapped space reads zero
    bus(1'b1, `LCG_OFF_GATE0_EN, 8'hFF, 4'hE);
    bus(1'b0, `LCG_OFF_GATE0_EN, 8'h00, 4'hF);
    chk(r, 32'h00000000);
    bus(1'b0, 8'h40, 8'h00, 4'hF);
    chk(r, 32'h00000000);
    // Walk each enable bit per gate, then random enables and inverts
    for (n = 0; n < 48; n++) begin
      en[n % 3] = n < 24 ? 8'h01 << (n / 3) : (n < 27 ? 8'h00 : 8'($urandom));
      inv = n < 27 ? 3'h0 : 3'($urandom);
      c3 = 5'($urandom);
      c4 = 5'($urandom);
      bus(1'b1, 8'(`LCG_OFF_GATE0_EN + 4 * (n % 3)), en[n % 3], 4'hF);
      bus(1'b1, `LCG_OFF_GATE_INV, {5'h00, inv}, 4'hF);
      bus(1'b1, `LCG_OFF_THIRD_SEL, {3'h7, c3}, 4'hF);
      bus(1'b1, `LCG_OFF_FOURTH_SEL, {3'h5, c4}, 4'hF);
      bus(1'b0, `LCG_OFF_THIRD_SEL, 8'h00, 4'hF);
      chk(r, {27'h0, c3});
      bus(1'b0, `LCG_OFF_FOURTH_SEL, 8'h00, 4'hF);
      chk(r, {27'h0, c4});
      bus(1'b0, 8'(`LCG_OFF_GATE0_EN + 4 * (n % 3)), 8'h00, 4'hF);
      chk(r, {24'h0, en[n % 3]});
      @(posedge clock);
      dIn1 <= 1'($urandom);
      dIn2 <= 1'($urandom);
      src <= $urandom;
      repeat (2) @(posedge clock);
      #1;
      for (g = 0; g < 3; g++) begin
        gx[g] = gexp(en[g], {src[c4], src[c3], dIn2, dIn1}) ^ inv[g];
        chk(gOut[g], gx[g]);
      end
      // Status shows the selected sources and the gate results
      bus(1'b0, `LCG_OFF_STATUS, 8'h00, 4'hF);
      chk(r, {27'h0, src[c4], src[c3], gx});
    end
    // Reset in mid-run clears the configuration again
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b0, `LCG_OFF_GATE2_EN, 8'h00, 4'hF);
    chk(r, 32'h00000000);
    chk(gOut, 3'h0);
    finishTest;
  end
endmodule // lcg_top_tb_top
